// [design/tone_pkg.sv]
// Shared constants, types and helper functions of the tone output generator.
package tone_pkg;

    // ---------------------------------------------------------------
    // Register bus geometry and map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] TONE_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] TONE_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Divider figures
    // ---------------------------------------------------------------
    // Nominal rate of the low-speed internal RC clock, in kHz.
    localparam int RC_NOMINAL_KHZ = 128;
    // Scale code that holds the prescaler idle; it is also the reset code.
    localparam logic [4:0] SCALE_IDLE_CODE = 5'h1F;
    // Scale factor is the code plus this base.
    localparam logic [5:0] SCALE_BASE = 6'h02;
    // Prescaler ticks per output half period for each ratio code.
    localparam logic [2:0] HALF_STEPS_DIV8 = 3'h4;
    localparam logic [2:0] HALF_STEPS_DIV4 = 3'h2;
    localparam logic [2:0] HALF_STEPS_DIV2 = 3'h1;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    // Control word layout, bit 7 down to bit 0.
    typedef struct packed {
        logic [1:0] tone_ratio_select;
        logic tone_enable;
        logic [4:0] calibrated_scale_value;
    } ctrl_t;

    // One register bus request as presented by the master.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Read-only status bits.
    typedef struct packed {
        logic level;
        logic running;
    } status_t;

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Scale factor from its 5-bit code.
    function automatic logic [5:0] scale_factor(input logic [4:0] code);
        return 6'(code) + SCALE_BASE;
    endfunction

    // Prescaler ticks per half period from the ratio code.
    function automatic logic [2:0] half_steps(input logic [1:0] ratio);
        return ratio[1] ? HALF_STEPS_DIV2 : (ratio[0] ? HALF_STEPS_DIV4 : HALF_STEPS_DIV8);
    endfunction

    // RC ticks per output half period.
    function automatic logic [7:0] half_period(input ctrl_t c);
        return 8'(scale_factor(c.calibrated_scale_value)) * 8'(half_steps(c.tone_ratio_select));
    endfunction

endpackage

// [design/tone_divider.sv]
// Prescaler and ratio divider chain that makes the square-wave tone.
`timescale 1ns/1ps

module tone_divider (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire tone_pkg::ctrl_t ctrl_in,
    output logic tone_out,
    output logic pre_tick_out,
    output logic toggle_out,
    output logic running_out
);

    // ---------------------------------------------------------------
    // Chain state
    // ---------------------------------------------------------------
    logic [5:0] pre_cnt_q; // RC ticks within one scale period.
    logic [5:0] pre_cnt_d;
    logic [2:0] post_cnt_q; // Scale periods within one half period.
    logic [2:0] post_cnt_d;
    logic tone_q; // Tone level.
    logic tone_d;
    wire logic [5:0] pre_last; // Last count of the prescaler.
    wire logic [2:0] post_last; // Last count of the ratio stage.
    wire logic pre_wrap;
    wire logic post_wrap;

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    // Idle while disabled or while the scale code is the idle code.
    assign running_out = ctrl_in.tone_enable && (ctrl_in.calibrated_scale_value != tone_pkg::SCALE_IDLE_CODE);
    // Factor is code plus two.
    assign pre_last = tone_pkg::scale_factor(ctrl_in.calibrated_scale_value) - 6'h01;
    // Half period spans 4, 2 or 1 scale periods.
    assign post_last = tone_pkg::half_steps(ctrl_in.tone_ratio_select) - 3'h1;
    // Compare with >= so a smaller factor written mid-run wraps at once.
    assign pre_wrap = pre_cnt_q >= pre_last;
    assign post_wrap = post_cnt_q >= post_last;
    assign pre_tick_out = running_out && tick_in && pre_wrap;
    assign toggle_out = pre_tick_out && post_wrap;
    assign tone_out = tone_q;

    // Next state; a stopped chain is held cleared and low.
    always_comb begin
        pre_cnt_d = pre_cnt_q;
        post_cnt_d = post_cnt_q;
        tone_d = tone_q;
        if (!running_out) begin
            pre_cnt_d = 6'h00;
            post_cnt_d = 3'h0;
            tone_d = 1'b0;
        end else if (tick_in) begin
            pre_cnt_d = pre_wrap ? 6'h00 : pre_cnt_q + 6'h01;
            if (pre_wrap) begin
                post_cnt_d = post_wrap ? 3'h0 : post_cnt_q + 3'h1;
            end
            if (toggle_out) begin
                tone_d = ~tone_q; // Flip each half period.
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_cnt_q <= 6'h00;
            post_cnt_q <= 3'h0;
            tone_q <= 1'b0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
            post_cnt_q <= post_cnt_d;
            tone_q <= tone_d;
        end
    end

endmodule

// [design/tone_output_generator.sv]
// Top of the tone output generator: register port, RC clock sampling, checks.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

module tone_output_generator (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic [tone_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [tone_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [tone_pkg::DATA_W-1:0] REG_RDATA_OUT,
    input wire logic LOW_SPEED_INTERNAL_RC_IN,
    output logic TONE_OUT
);

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    // Bundled request, for readability of the decode.
    wire tone_pkg::reg_req_t req;
    assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

    // The control word; status is a separate word.
    tone_pkg::ctrl_t ctrl_q;
    // Read data, valid only in the cycle after a read strobe.
    logic [tone_pkg::DATA_W-1:0] rdata_q;
    // Decoded strobes.
    wire logic wr_ctrl;
    wire logic rd_ctrl;
    wire logic rd_status;
    // Value returned by the current read.
    wire logic [tone_pkg::DATA_W-1:0] rd_value;
    // Block state shown to software.
    wire tone_pkg::status_t status;

    assign wr_ctrl = req.wr && (req.addr == tone_pkg::TONE_CTRL_OFFSET);
    assign rd_ctrl = req.rd && (req.addr == tone_pkg::TONE_CTRL_OFFSET);
    assign rd_status = req.rd && (req.addr == tone_pkg::TONE_STATUS_OFFSET);
    // Reserved bits and unmapped offsets read as zero. Every path of the
    // select ends in a constant or a register, so the read port never
    // shows an unknown, even before the first write.
    assign rd_value = rd_ctrl ? {24'h00_0000, ctrl_q} :
                      rd_status ? {30'h0000_0000, status} : tone_pkg::READ_ZERO;

    // Control word. Writes take effect at once; software is expected to
    // calibrate, then pick the ratio, then enable, which keeps the tone
    // from starting at a stale rate.
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl_q <= tone_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= tone_pkg::ctrl_t'(req.wdata[7:0]);
        end
    end

    // Read data register; zero in every cycle not following a read.
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rdata_q <= tone_pkg::READ_ZERO;
        end else begin
            rdata_q <= rd_value;
        end
    end

    assign REG_RDATA_OUT = rdata_q;

    // ---------------------------------------------------------------
    // RC clock sampling
    // ---------------------------------------------------------------
    // The RC clock is asynchronous to MCLK_IN, so it is synchronised and
    // turned into a one-cycle tick per rising edge. MCLK_IN must run far
    // faster than the RC clock, which at 100 MHz against 128 kHz it does.
    logic rc_meta_q; // First stage; read only by the second.
    logic rc_sync_q; // Second stage.
    logic rc_prev_q; // Delayed copy for edge detection.
    wire logic rc_tick;

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_meta_q <= LOW_SPEED_INTERNAL_RC_IN;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end

    // Tone timing counts RC edges only, so the tone rate follows the RC
    // clock however fast MCLK_IN runs. The edge flop resets low, the idle
    // level of the pin, so no false tick follows reset.
    assign rc_tick = rc_sync_q && !rc_prev_q;

    // ---------------------------------------------------------------
    // Divider chain
    // ---------------------------------------------------------------
    wire logic pre_tick; // End of one scale period.
    wire logic toggle; // End of one half period.
    wire logic running; // Chain is counting.

    // The chain counts whole RC ticks and has no notion of MCLK_IN time,
    // which keeps the tone exact whatever the ratio, so long as MCLK_IN runs fast enough for the sampler to see every RC edge.

    tone_divider u_divider (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .tick_in(rc_tick),
        .ctrl_in(ctrl_q),
        .tone_out(TONE_OUT),
        .pre_tick_out(pre_tick),
        .toggle_out(toggle),
        .running_out(running)
    );

    // Status is read back live with no latch, so it lags the pin by the
    // one cycle of the read data register.
    assign status = '{level: TONE_OUT, running: running};

    // ---------------------------------------------------------------
    // Check helpers
    // ---------------------------------------------------------------
    // RC ticks since the last half-period end, and since the last
    // scale-period end. The first interval after a write or a stop is
    // irregular, so the seen flags gate the checks until one full
    // interval has been observed.
    // Chain-on condition worked out from the control word itself, so the
    // helpers below do not lean on the divider's own running flag and a
    // stuck chain shows up as a counter that grows past its bound.
    wire logic chain_on;
    assign chain_on = ctrl_q.tone_enable && (ctrl_q.calibrated_scale_value != tone_pkg::SCALE_IDLE_CODE);

    logic [7:0] gap_q;
    logic gap_seen_q;
    logic [5:0] pre_gap_q;
    logic pre_seen_q;

    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            gap_q <= 8'h00;
            gap_seen_q <= 1'b0;
            pre_gap_q <= 6'h00;
            pre_seen_q <= 1'b0;
        end else if (wr_ctrl || !chain_on) begin
            gap_q <= 8'h00;
            gap_seen_q <= 1'b0;
            pre_gap_q <= 6'h00;
            pre_seen_q <= 1'b0;
        end else if (rc_tick) begin
            gap_q <= toggle ? 8'h00 : gap_q + 8'h01;
            gap_seen_q <= gap_seen_q || toggle;
            pre_gap_q <= pre_tick ? 6'h00 : pre_gap_q + 6'h01;
            pre_seen_q <= pre_seen_q || pre_tick;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // Half period equals factor times ratio over two, in RC ticks.
    property p_half_period;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (toggle && gap_seen_q) |-> (gap_q + 8'h01 == tone_pkg::half_period(ctrl_q));
    endproperty
    a_half_period: assert property (p_half_period) else $error("tone half period wrong");

    // Scale period equals code plus two RC ticks.
    property p_scale_period;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (pre_tick && pre_seen_q) |->
            (pre_gap_q + 6'h01 == tone_pkg::scale_factor(ctrl_q.calibrated_scale_value));
    endproperty
    a_scale_period: assert property (p_scale_period) else $error("scale period wrong");

    // Each half-period end flips the output on the next edge.
    property p_tone_flip;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (toggle && !wr_ctrl) |=> (TONE_OUT != $past(TONE_OUT));
    endproperty
    a_tone_flip: assert property (p_tone_flip) else $error("tone did not flip");

    // A cleared enable forces a low output from the next edge on.
    property p_disabled_low;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !ctrl_q.tone_enable |=> !TONE_OUT;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("tone high while disabled");

    // Enable set with a usable code means the chain runs.
    property p_enable_runs;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ctrl_q.tone_enable && ctrl_q.calibrated_scale_value != tone_pkg::SCALE_IDLE_CODE) |-> running;
    endproperty
    a_enable_runs: assert property (p_enable_runs) else $error("chain idle while enabled");

    // The idle code keeps the prescaler still and the output low.
    property p_idle_code;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (ctrl_q.calibrated_scale_value == tone_pkg::SCALE_IDLE_CODE) |-> (!pre_tick ##1 !TONE_OUT);
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("prescaler ran on idle code");

    // A control write is visible from the next edge.
    property p_ctrl_write;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        wr_ctrl |=> (ctrl_q == $past(REG_WDATA_IN[7:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Read data appear one cycle after the strobe and only then.
    property p_read_data;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        rd_ctrl |=> (REG_RDATA_OUT == {24'h00_0000, $past(ctrl_q)}) ##1 (REG_RDATA_OUT == 32'h0 || $past(REG_RD_IN));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    // Read data fall back to zero in every cycle that does not follow a
    // read, so a late sampler cannot pick up a stale word.
    property p_rdata_idle;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        !REG_RD_IN |=> (REG_RDATA_OUT == tone_pkg::READ_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

    // Status reads report the level and the chain-on state of the cycle
    // of the strobe; chain-on is derived here, not taken from the divider.
    property p_status_read;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        rd_status |=>
            (REG_RDATA_OUT == {30'h0000_0000, $past(TONE_OUT), $past(chain_on)});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // Reads of unmapped offsets return zero, so software probing the map
    // sees no aliases of the control word.
    property p_unmapped_read;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (req.rd && !rd_ctrl && !rd_status) |=> (REG_RDATA_OUT == tone_pkg::READ_ZERO);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // Writes to any other offset leave the control word alone; the status
    // word is read only and writing it must not disturb the tone.
    property p_write_ignored;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        (req.wr && (req.addr != tone_pkg::TONE_CTRL_OFFSET)) |=> $stable(ctrl_q);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("control word changed by other write");

    // The output moves only at a half-period end or when the chain stops;
    // any other edge on the pin would be an audible glitch.
    property p_tone_steady;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        $changed(TONE_OUT) |-> ($past(toggle) || !$past(running));
    endproperty
    a_tone_steady: assert property (p_tone_steady) else $error("tone moved between half periods");

    // A running prescaler ends its scale period within the factor. A write
    // mid-run may shorten one period, never stretch it.
    property p_prescale_bound;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        chain_on |->
            (pre_gap_q < tone_pkg::scale_factor(ctrl_q.calibrated_scale_value));
    endproperty
    a_prescale_bound: assert property (p_prescale_bound) else $error("scale period overran");

    // A half period never runs past factor times the ratio steps, which
    // also catches a chain that is enabled but never counts.
    property p_half_bound;
        @(posedge MCLK_IN) disable iff (RESET_IN)
        chain_on |-> (gap_q < tone_pkg::half_period(ctrl_q));
    endproperty
    a_half_bound: assert property (p_half_bound) else $error("half period overran");

    // ---------------------------------------------------------------
    // Cover points
    // ---------------------------------------------------------------
    // Tone at each ratio: codes 00 and 01 apart, codes 10 and 11 together.
    c_ratio8: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        toggle && gap_seen_q && ctrl_q.tone_ratio_select == 2'b00);
    c_ratio4: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        toggle && gap_seen_q && ctrl_q.tone_ratio_select == 2'b01);
    c_ratio2: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        toggle && gap_seen_q && ctrl_q.tone_ratio_select[1]);
    // Disable while the tone is high.
    c_stop_high: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        TONE_OUT && wr_ctrl && !REG_WDATA_IN[5]);
    // First cycle of a running chain.
    c_start: cover property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $rose(running));

endmodule

// [bench/tb_tone_output_generator.sv]
// Self-checking testbench of the tone output generator.
`timescale 1ns/1ps

module tb_tone_output_generator;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic mclk; // System clock, 100 MHz.
    logic reset; // Asynchronous reset, active high.
    logic [tone_pkg::ADDR_W-1:0] reg_addr; // Register byte address.
    logic [tone_pkg::DATA_W-1:0] reg_wdata; // Register write data.
    logic reg_wr; // Write strobe.
    logic reg_rd; // Read strobe.
    logic [tone_pkg::DATA_W-1:0] rdata; // Read data from the block.
    logic [31:0] rd_val; // Last value captured by a read.
    logic rc; // Stand-in for the slow RC clock.
    logic tone; // Tone output of the block.
    int fail_count; // Mismatches seen.
    int n_compared; // Comparisons made.
    int rc_edges; // Rising edges of the RC clock so far.
    int rc_div; // Divider that makes the RC clock from the system clock.
    int snap; // RC edge count at the last tone transition.
    logic [4:0] codes [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h1E, 5'h0E}; // Scale codes per case.
    logic [1:0] ratios [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1}; // Ratio codes per case.

    tone_output_generator dut_u (
        .MCLK_IN(mclk),
        .RESET_IN(reset),
        .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata),
        .REG_WR_IN(reg_wr),
        .REG_RD_IN(reg_rd),
        .REG_RDATA_OUT(rdata),
        .LOW_SPEED_INTERNAL_RC_IN(rc),
        .TONE_OUT(tone)
    );

    // ---------------------------------------------------------------
    // Clock and RC clock
    // ---------------------------------------------------------------
    // The system clock toggles every half period.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The RC clock runs at 10 system cycles a period, slow enough for the two-flop sampler to see every edge.
    always @(posedge mclk) begin
        if (rc_div == 4) begin
            rc_div <= 0;
            rc <= ~rc;
            if (!rc) begin
                rc_edges <= rc_edges + 1;
            end
        end else begin
            rc_div <= rc_div + 1;
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    // Compares a seen value with the expected one and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the gap cycle afterwards keeps strobes from being driven twice in one step.
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; data is taken in the single cycle after it.
    task automatic reg_read(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = rdata;
    endtask

    // Waits for a tone level under a bound, so a dead divider cannot hang the run.
    task automatic wait_tone(input logic lvl);
        int k;
        k = 0;
        while (tone !== lvl && k < 4000) begin
            @(posedge mclk);
            #1 k++;
        end
        if (k >= 4000) begin
            check(32'(tone), 32'(lvl));
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    // Main sequence: register behaviour, idle code, then every ratio code over a range of scale codes.
    initial begin
        int half;
        logic [7:0] cw;
        int meas;
        int a_int;
        int frac;
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rc = 1'b0;
        rc_div = 0;
        rc_edges = 0;
        fail_count = 0;
        n_compared = 0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        // Reset value, unmapped place, read-only status and ignored upper bits.
        reg_read(8'h00);
        check(rd_val, 32'h0000_001F);
        @(posedge mclk);
        #1 check(rdata, 32'h0000_0000);
        reg_read(8'h08);
        check(rd_val, 32'h0000_0000);
        reg_write(8'h04, 32'h0000_00FF);
        reg_read(8'h00);
        check(rd_val, 32'h0000_001F);
        reg_write(8'h00, 32'hFFFF_FF3F);
        reg_read(8'h00);
        check(rd_val, 32'h0000_003F);
        $display("test register access done");
        // Enabled with the idle code the prescaler must not run.
        repeat (200) @(posedge mclk);
        #1 check(32'(tone), 32'h0);
        reg_read(8'h04);
        check(rd_val, 32'h0000_0000);
        reg_write(8'h00, 32'h0000_0020);
        wait_tone(1'b1);
        reg_write(8'h00, 32'h0000_0000);
        $display("test idle code done");
        // Calibration. The bench RC clock has ten system cycles a period, so 1280 cycles hold as many
        // RC edges as the nominal clock gives in one millisecond and the count reads in kHz.
        // The nominal count must give the scale code of a 1 kHz tone at ratio code 00.
        @(posedge mclk);
        #1 snap = rc_edges;
        repeat (1280) @(posedge mclk);
        #1 meas = rc_edges - snap;
        a_int = meas / 8;
        frac = meas % 8;
        codes[5] = (frac * (1 + 2 * a_int) <= 8 * a_int) ? 5'(a_int - 2) : 5'(a_int - 1);
        check(32'(codes[5]), 32'h0000_000E);
        $display("test calibration done");
        // Each case brings the unit up in order, measures two half periods, then switches it off.
        for (int i = 0; i < 6; i++) begin
            cw = {ratios[i], 1'b0, codes[i]};
            half = (int'(codes[i]) + 2) * (ratios[i][1] ? 1 : (ratios[i][0] ? 2 : 4));
            reg_write(8'h00, {27'h0, codes[i]});
            reg_write(8'h00, {24'h0, cw});
            reg_read(8'h00);
            check(rd_val, {24'h0, cw});
            check(32'(tone), 32'h0);
            reg_write(8'h00, {24'h0, cw | 8'h20});
            reg_read(8'h04);
            check(rd_val & 32'h1, 32'h1);
            wait_tone(1'b1);
            snap = rc_edges;
            wait_tone(1'b0);
            check(32'(rc_edges - snap), 32'(half));
            snap = rc_edges;
            wait_tone(1'b1);
            check(32'(rc_edges - snap), 32'(half));
            reg_write(8'h00, {24'h0, cw});
            repeat (3) @(posedge mclk);
            #1 check(32'(tone), 32'h0);
            reg_read(8'h04);
            check(rd_val, 32'h0000_0000);
            $display("test ratio %0d scale %0d done", ratios[i], codes[i]);
        end
        test_done();
    end

    // Watchdog: the whole sequence needs well under 60,000 cycles.
    initial begin
        #600_000;
        fail_count++;
        test_done();
    end

endmodule
